//--- flash_host_defines.svh
// Timing counts, address field positions and pin levels for the flash host controller.
// Assumes a 20 MHz ref_clk and a 22-bit word-mode address bus with a 16-bit data bus.
//
// Functional notes
// - Array read drives chip select and output enable low, write enable high.
// - Fast in-page reads only while page stays constant and chip select stays low.
// - Command write cycle drives write enable and chip select low, output enable high.
// - Host waits the read-after-reset delay after reset before reading.
// - Group protect needs high voltage on ID line and output enable, select line low.
// - Chip unprotect needs high voltage on output enable and ID line, select line high.
// - Protect and unprotect also work with high voltage on reset and normal cycles.
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

`define FH_CLK_PERIOD_NS 50
`define FH_CYC_UP(t) (((t) + `FH_CLK_PERIOD_NS - 1) / `FH_CLK_PERIOD_NS)

// Times in ns as printed or as plain defaults
`define FH_T_ACC_NS 90
`define FH_T_PAGE_NS 25
`define FH_T_WP_NS 35
`define FH_T_RP_NS 500
`define FH_T_RH_NS 50
`define FH_T_READY_NS 20000
`define FH_T_PROT_NS 100000

// Cycle counts derived from the times
`define FH_ACC_CYC `FH_CYC_UP(`FH_T_ACC_NS)
`define FH_PAGE_CYC `FH_CYC_UP(`FH_T_PAGE_NS)
`define FH_WP_CYC `FH_CYC_UP(`FH_T_WP_NS)
`define FH_RP_CYC `FH_CYC_UP(`FH_T_RP_NS)
`define FH_RH_CYC `FH_CYC_UP(`FH_T_RH_NS)
`define FH_READY_CYC `FH_CYC_UP(`FH_T_READY_NS)
`define FH_PROT_CYC `FH_CYC_UP(`FH_T_PROT_NS)

// Address fields
`define FH_ADDR_W 22
`define FH_DATA_W 16
`define FH_PAGE_LSB 2
`define FH_QUERY_BIT 1
`define FH_LOW_BIT 0
`define FH_PSEL_BIT 6
`define FH_BUF_WORDS 16

// Read-identification command word; value chosen freely, not a real device code
`define FH_ID_CMD 16'h00A5

`endif

//--- flash_host_pkg.sv
// Types shared by the flash host controller and its testbench.
// Widths come from flash_host_defines.svh.
`include "flash_host_defines.svh"

package flash_host_pkg;

  // Operations the user may order
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_RESET = 3'h2,
    OP_PROTECT = 3'h3,
    OP_UNPROTECT = 3'h4,
    OP_VERIFY = 3'h5
  } op_t;

  // One user order
  typedef struct packed {
    op_t op;
    logic altReset;
    logic [`FH_ADDR_W-1:0] addr;
    logic [`FH_DATA_W-1:0] data;
  } cmd_t;

  // Pins toward the flash; high-voltage lines are requests to the level shifters
  typedef struct packed {
    logic ceN;
    logic oeN;
    logic weN;
    logic resetN;
    logic idHv;
    logic oeHv;
    logic resetHv;
    logic accHv;
    logic wpN;
    logic [`FH_ADDR_W-1:0] addr;
    logic [`FH_DATA_W-1:0] dataOut;
    logic dataOe;
  } pins_t;

endpackage : flash_host_pkg

//--- flash_host_ctrl.sv
// Host-side controller that drives a parallel NOR flash through its pins.
// Assumes pins are synchronous to ref_clk and high-voltage lines go through external switches.
`timescale 1ns/1ps
`include "flash_host_defines.svh"

module flash_host_ctrl
  import flash_host_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // User orders
  input wire logic cmdValid,
  input cmd_t cmd,
  output logic cmdReady,
  output logic rspValid,
  output logic [`FH_DATA_W-1:0] rspData,
  // Static pin requests
  input wire logic accLevel,
  input wire logic wpLevel,
  // Flash pins
  output pins_t pins,
  input wire logic [`FH_DATA_W-1:0] dataIn,
  input wire logic readyBusyN
);

  // ----------------------------------------------------------------
  // State and counters
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_ACCESS = 8'h02,
    S_WSETUP = 8'h04,
    S_WPULSE = 8'h08,
    S_WHOLD = 8'h10,
    S_RLOW = 8'h20,
    S_RBUSY = 8'h40,
    S_RREC = 8'h80
  } state_t;

  state_t state;
  state_t next_state;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic pageValid;
  logic [`FH_ADDR_W-1:`FH_PAGE_LSB] pageAddr;
  cmd_t cur;
  pins_t next_pins;

  // ----------------------------------------------------------------
  // Decode of the incoming order
  // ----------------------------------------------------------------
  wire take = cmdValid && cmdReady;
  wire isRead = cmd.op == OP_READ;
  wire isVerify = cmd.op == OP_VERIFY;
  wire isProt = (cmd.op == OP_PROTECT) || (cmd.op == OP_UNPROTECT);
  wire hvProt = isProt && !cmd.altReset;
  wire samePage = pageValid && (cmd.addr[`FH_ADDR_W-1:`FH_PAGE_LSB] == pageAddr);
  wire fastRead = isRead && samePage && !pins.ceN;
  // High-voltage protect and verify force the group-select address pattern
  wire [`FH_ADDR_W-1:0] protAddr = {cmd.addr[`FH_ADDR_W-1:7],
    cmd.op == OP_UNPROTECT, cmd.addr[5:2], 1'b1, 1'b0};
  wire [`FH_ADDR_W-1:0] verAddr = {cmd.addr[`FH_ADDR_W-1:7], 1'b0,
    cmd.addr[5:2], 1'b1, 1'b0};
  wire [`FH_ADDR_W-1:0] useAddr = hvProt ? protAddr : (isVerify ? verAddr : cmd.addr);
  wire [11:0] readCyc = fastRead ? 12'(`FH_PAGE_CYC) : 12'(`FH_ACC_CYC);
  wire [11:0] pulseCyc = hvProt ? 12'(`FH_PROT_CYC) : 12'(`FH_WP_CYC);
  wire cntDone = cnt == 12'h001;

  // ----------------------------------------------------------------
  // Next state and pin values
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cntDone ? cnt : cnt - 12'h001;
    next_pins = pins;
    next_pins.accHv = accLevel;
    next_pins.wpN = !wpLevel;
    case (state)
      S_IDLE: begin
        if (take) begin
          next_pins.addr = useAddr;
          next_pins.dataOut = cmd.data;
          next_pins.idHv = hvProt || isVerify;
          next_pins.resetHv = isProt && cmd.altReset;
          if (cmd.op == OP_RESET) begin
            next_pins.ceN = 1'b1;
            next_pins.oeN = 1'b1;
            next_pins.dataOe = 1'b0;
            next_pins.resetN = 1'b0;
            next_cnt = 12'(`FH_RP_CYC);
            next_state = S_RLOW;
          end else if (isRead || isVerify) begin
            next_pins.weN = 1'b1;
            next_pins.dataOe = 1'b0;
            next_pins.ceN = 1'b0;
            next_pins.oeN = 1'b0;
            next_cnt = readCyc;
            next_state = S_ACCESS;
          end else begin
            // Writes and protect cycles start from a released bus
            next_pins.oeN = 1'b1;
            next_pins.oeHv = hvProt;
            next_pins.ceN = 1'b0;
            next_pins.dataOe = 1'b1;
            next_cnt = pulseCyc;
            next_state = S_WSETUP;
          end
        end
      end
      S_ACCESS: begin
        if (cntDone) begin
          next_pins.oeN = 1'b1;
          next_pins.idHv = 1'b0;
          next_state = S_IDLE;
        end
      end
      S_WSETUP: begin
        // Count is held here so the low pulse lasts the full count
        next_cnt = cnt;
        next_pins.weN = 1'b0;
        next_state = S_WPULSE;
      end
      S_WPULSE: begin
        if (cntDone) begin
          next_pins.weN = 1'b1;
          next_state = S_WHOLD;
        end
      end
      S_WHOLD: begin
        next_pins.ceN = 1'b1;
        next_pins.dataOe = 1'b0;
        next_pins.oeHv = 1'b0;
        next_pins.idHv = 1'b0;
        next_pins.resetHv = 1'b0;
        next_state = S_IDLE;
      end
      S_RLOW: begin
        if (cntDone) begin
          next_pins.resetN = 1'b1;
          next_cnt = 12'(`FH_READY_CYC);
          next_state = S_RBUSY;
        end
      end
      S_RBUSY: begin
        // Waits out a reset during program or erase, bounded in case the pin is absent
        if (readyBusyN || cntDone) begin
          next_cnt = 12'(`FH_RH_CYC);
          next_state = S_RREC;
        end
      end
      S_RREC: begin
        if (cntDone) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Chip select is kept low after a read so a following in-page read runs fast
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= S_IDLE;
      cnt <= 12'h001;
      pins <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, resetN: 1'b1, wpN: 1'b1, default: '0};
      cur <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pins <= next_pins;
      if (take) begin
        cur <= cmd;
      end
    end
  end

  // Page tracking is dropped by anything that raises chip select
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pageValid <= 1'b0;
      pageAddr <= '0;
    end else if (take) begin
      pageValid <= isRead;
      pageAddr <= cmd.addr[`FH_ADDR_W-1:`FH_PAGE_LSB];
    end
  end

  // Answer and readiness
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmdReady <= 1'b1;
      rspValid <= 1'b0;
      rspData <= '0;
    end else begin
      cmdReady <= next_state == S_IDLE;
      rspValid <= (state != S_IDLE) && (next_state == S_IDLE);
      if (state == S_ACCESS && cntDone) begin
        // Verify returns only the protection flag on bit 0
        rspData <= (cur.op == OP_VERIFY) ? {15'h0000, dataIn[0]} : dataIn;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence resetHeld;
    !pins.resetN [*8] ##1 !pins.resetN [*2];
  endsequence

  a_read_levels: assert property (!pins.oeN |-> pins.weN && !pins.ceN && !pins.dataOe)
    else $error("read cycle with bad control levels");
  a_write_levels: assert property (!pins.weN |-> !pins.ceN && pins.oeN && pins.dataOe)
    else $error("write pulse with bad control levels");
  a_bus_release: assert property (!pins.oeN |-> !pins.dataOe)
    else $error("host drives data while device may drive");
  a_reset_width: assert property ($fell(pins.resetN) |-> resetHeld)
    else $error("reset pulse shorter than minimum");
  a_reset_recovery: assert property ($rose(pins.resetN) |-> pins.oeN [*2])
    else $error("read started before read-after-reset delay");
  a_page_fast: assert property (
    take && isRead && !fastRead |=> !pins.oeN [*2])
    else $error("full access shortened");
  a_protect_pins: assert property (
    !pins.weN && pins.oeHv |-> pins.idHv && pins.addr[`FH_QUERY_BIT] && !pins.addr[0])
    else $error("protect pulse without high-voltage setup");
  a_unprotect_sel: assert property (
    take && hvProt |=> pins.addr[`FH_PSEL_BIT] == (cur.op == OP_UNPROTECT))
    else $error("protect-select line wrong for operation");
  a_alt_reset: assert property (take && isProt && cmd.altReset |=> pins.resetHv && !pins.oeHv)
    else $error("alternate protect without reset high voltage");
  a_verify_read: assert property (
    !pins.oeN && pins.idHv |-> pins.addr[`FH_QUERY_BIT] && !pins.addr[`FH_PSEL_BIT])
    else $error("verify read with wrong address pattern");

endmodule : flash_host_ctrl

//--- flash_model.sv
// Behavioural flash device seen from its pins: array reads, verify reads, protection, busy.
// Assumes pins change just after ref_clk edges; no byte mode, no program contents.
`timescale 1ns/1ps
`include "flash_host_defines.svh"
// ----------------------------------------
// Device model
// ----------------------------------------
module flash_model
  import flash_host_pkg::*;
(
  // Shared clock
  input wire logic ref_clk,
  // Pins from the host
  input pins_t pins,
  // Pins back to the host
  output logic [15:0] dataIn,
  output logic readyBusyN
);
  logic [31:0] prot = 32'h0;
  logic [15:0] held = 16'h0;
  logic lastWe = 1'b1;
  logic idMode = 1'b0;
  int busy = 0;
  // Output only on a read cycle outside reset; a floating bus toggles every cycle
  wire drive = !pins.ceN && !pins.oeN && pins.weN && pins.resetN;
  // Data depends on the address only, so it stays put while the address rests
  wire [15:0] arrayWord = {pins.addr[7:0], ~pins.addr[15:8]};
  wire [15:0] verWord = {15'h0, prot[pins.addr[21:17]]};
  wire verMode = (pins.idHv || idMode) && pins.addr[1];
  assign dataIn = drive ? (verMode ? verWord : arrayWord) : ~held;
  // Protection writes on the write-enable rising edge; busy survives reset for a while
  always @(posedge ref_clk) begin
    held <= dataIn;
    lastWe <= pins.weN;
    readyBusyN <= (busy == 0);
    if (!pins.resetN)
      idMode <= 1'b0;
    if (lastWe === 1'b0 && pins.weN === 1'b1 && !pins.ceN) begin
      if ((pins.idHv && pins.oeHv) || pins.resetHv) begin
        if (pins.addr[6])
          prot <= 32'h0;
        else
          prot[pins.addr[21:17]] <= 1'b1;
      end else if (pins.resetN) begin
        busy <= 6;
        // Any other command word drops back to array read
        idMode <= pins.dataOut == `FH_ID_CMD;
      end
    end else if (!pins.resetN && busy > 0)
      busy <= 20;
    else if (busy > 0)
      busy <= busy - 1;
  end
endmodule : flash_model

//--- parallel_flash_bus_and_protect_bench.sv
// Self-checking bench for the flash host controller against a behavioural device.
// Assumes flash_model.sv and the design files are compiled first.
`timescale 1ns/1ps
`include "flash_host_defines.svh"
// ----------------------------------------
// Testbench top
// ----------------------------------------
module parallel_flash_bus_and_protect_bench;
  import flash_host_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic cmdValid = 1'b0;
  cmd_t cmd = '0;
  logic [15:0] wData = 16'h0000;
  logic accLevel = 1'b0;
  logic wpLevel = 1'b0;
  logic cmdReady, rspValid, readyBusyN;
  logic [15:0] rspData, dataIn;
  pins_t pins;
  int fails = 0;
  int cmp_count = 0;
  int weCnt = 0;
  int weLast = 0;
  int rstCnt = 0;
  int rstLast = 0;
  bit prot[int];
  int lat, i, a, g;
  op_t ops[4] = '{OP_PROTECT, OP_UNPROTECT, OP_PROTECT, OP_UNPROTECT};

  flash_host_ctrl flash_host_ctrl_i (.ref_clk(ref_clk), .rstn(rstn), .cmdValid(cmdValid),
    .cmd(cmd), .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
    .accLevel(accLevel), .wpLevel(wpLevel), .pins(pins), .dataIn(dataIn),
    .readyBusyN(readyBusyN));
  flash_model flash_model_i (.ref_clk(ref_clk), .pins(pins), .dataIn(dataIn),
    .readyBusyN(readyBusyN));

  always #25 ref_clk = ~ref_clk;

  // Low-pulse widths of write enable and device reset, in cycles
  always @(posedge ref_clk) begin
    weCnt = (pins.weN === 1'b0) ? weCnt + 1 : 0;
    rstCnt = (pins.resetN === 1'b0) ? rstCnt + 1 : 0;
    if (weCnt > 0)
      weLast = weCnt;
    if (rstCnt > 0)
      rstLast = rstCnt;
  end

  function automatic int exp_word(int x);
    return ((x & 255) << 8) | ((~(x >> 8)) & 255);
  endfunction : exp_word

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic check(string name, logic [31:0] exp, logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // One order: wait for ready, hand it over, count edges to the response
  task automatic run_op(op_t op, logic alt, int x, output int n);
    int k;
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmd <= '{op: op, altReset: alt, addr: x[21:0], data: wData};
    // Next order gets random data that never forms the identification command
    wData = 16'($urandom);
    if (wData == `FH_ID_CMD)
      wData = ~wData;
    for (k = 0; k < 50; k++) begin
      #1;
      if (cmdReady === 1'b1)
        break;
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    for (n = 1; n < 3000; n++) begin
      @(posedge ref_clk);
      #1;
      if (rspValid === 1'b1)
        break;
    end
    if (k >= 50 || n >= 3000) begin
      fails++;
      close_out();
    end
  endtask : run_op

  initial begin
    void'($urandom(36));
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    // Page reads straight after reset, then a write closes the page
    a = $urandom & 32'h3FFFFC;
    for (i = 0; i < 4; i++) begin
      run_op(OP_READ, 1'b0, a | (3 - i), lat);
      check("read data", exp_word(a | (3 - i)), rspData);
      check("read cycles", (i == 0) ? `FH_ACC_CYC : `FH_PAGE_CYC, lat);
    end
    check("outputs disabled", 1, pins.oeN);
    run_op(OP_WRITE, 1'b0, a, lat);
    check("write cycles", `FH_WP_CYC + 2, lat);
    check("write pulse", `FH_WP_CYC, weLast);
    check("standby select", 1, pins.ceN);
    run_op(OP_READ, 1'b0, a | 1, lat);
    check("reopened page cycles", `FH_ACC_CYC, lat);
    $display("done: page reads and writes");
    // Reset while the device is busy with a program
    run_op(OP_WRITE, 1'b0, a, lat);
    run_op(OP_RESET, 1'b0, a, lat);
    check("reset pulse", `FH_RP_CYC, rstLast);
    check("reset waits for ready", 1, (lat > 30) && (readyBusyN === 1'b1));
    run_op(OP_READ, 1'b0, a, lat);
    check("read after reset", exp_word(a), rspData);
    $display("done: device reset");
    // Protect and unprotect, high-voltage and reset-pin methods, each verified
    for (i = 0; i < 4; i++) begin
      a = ($urandom & 32'h3FFFBF) | ((ops[i] == OP_UNPROTECT) ? 64 : 0);
      g = a >> 17;
      run_op(ops[i], i >= 2, a, lat);
      if (ops[i] == OP_PROTECT)
        prot[g] = 1'b1;
      else
        prot.delete();
      check("protect cycles", (i >= 2) ? `FH_WP_CYC + 2 : `FH_PROT_CYC + 2, lat);
      check("protect pulse", (i >= 2) ? `FH_WP_CYC : `FH_PROT_CYC, weLast);
      run_op(OP_VERIFY, 1'b0, a, lat);
      check("verify group", prot.exists(g), rspData);
      run_op(OP_VERIFY, 1'b0, a ^ 32'h20000, lat);
      check("verify other group", prot.exists(g ^ 1), rspData);
    end
    $display("done: group protection");
    // In-system identification read, then a stray write returns to array read
    a = $urandom & 32'h3FFFBF;
    g = a >> 17;
    run_op(OP_PROTECT, 1'b1, a, lat);
    prot[g] = 1'b1;
    wData = `FH_ID_CMD;
    run_op(OP_WRITE, 1'b0, a, lat);
    run_op(OP_READ, 1'b0, a | 2, lat);
    check("identification read", prot.exists(g), rspData);
    run_op(OP_READ, 1'b0, (a ^ 32'h20000) | 2, lat);
    check("identification other group", prot.exists(g ^ 1), rspData);
    run_op(OP_WRITE, 1'b0, a, lat);
    run_op(OP_READ, 1'b0, a | 2, lat);
    check("array after stray write", exp_word(a | 2), rspData);
    // A full buffer of back-to-back writes, never more than the buffer holds
    for (i = 0; i < `FH_BUF_WORDS; i++) begin
      run_op(OP_WRITE, 1'b0, a + i, lat);
      check("buffer write cycles", `FH_WP_CYC + 2, lat);
    end
    $display("done: identification and buffer writes");
    // Acceleration and write-protect requests reach the pins
    for (i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      accLevel <= i[0];
      wpLevel <= i[1];
      repeat (2) @(posedge ref_clk);
      #1;
      check("acceleration request", i[0], pins.accHv);
      check("write protect pin", !i[1], pins.wpN);
    end
    $display("done: static pins");
    close_out();
  end
endmodule : parallel_flash_bus_and_protect_bench
